// ### logic/iefc_pkg.sv
// package: register map, field positions and reset values of the interrupt control block
package iefc_pkg;

   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [11:0] IEFC_ADDR_CONTROL    = 12'h000;
   localparam logic [11:0] IEFC_ADDR_PERIPH_EN  = 12'h004;
   localparam logic [11:0] IEFC_ADDR_PERIPH_FLG = 12'h008;
   localparam logic [11:0] IEFC_ADDR_PIN_FLAGS  = 12'h00C;
   localparam logic [11:0] IEFC_ADDR_OPTION     = 12'h010;

   // ----------------------------------------
   // control register fields
   // ----------------------------------------
   localparam int IEFC_GLOBAL_BIT     = 7;
   localparam int IEFC_PERIPH_GRP_BIT = 6;
   localparam int IEFC_TIMER_EN_BIT   = 5;
   localparam int IEFC_EDGE_EN_BIT    = 4;
   localparam int IEFC_PIN_EN_BIT     = 3;
   localparam int IEFC_TIMER_FLG_BIT  = 2;
   localparam int IEFC_EDGE_FLG_BIT   = 1;
   localparam int IEFC_PIN_SUM_BIT    = 0;

   // ----------------------------------------
   // peripheral enable / flag fields
   // ----------------------------------------
   localparam int IEFC_CONV_BIT  = 6;
   localparam int IEFC_OSC_BIT   = 4;
   localparam int IEFC_CELL_BIT  = 3;
   localparam int IEFC_MATCH_BIT = 1;
   localparam logic [7:0] IEFC_PERIPH_MASK = 8'h5A;

   // option register: edge polarity at bit 6
   localparam int IEFC_EDGE_POL_BIT = 6;

   // ----------------------------------------
   // reset values and widths
   // ----------------------------------------
   localparam logic [7:0] IEFC_CONTROL_RST = 8'h00;
   localparam logic [7:0] IEFC_PERIPH_RST  = 8'h00;
   localparam int         IEFC_PIN_COUNT   = 4;

endpackage : iefc_pkg

// ### logic/iefc_sync.sv
// two-flop synchroniser for a bus of asynchronous inputs
module iefc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // data
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // iefc_sync

// ### logic/iefc_edge_detect.sv
// edge detector on synchronised inputs, one-cycle pulses out
module iefc_edge_detect #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // levels in, pulses out
   input  wire logic [WIDTH-1:0] level_in,
   output      logic [WIDTH-1:0] rise_out,
   output      logic [WIDTH-1:0] fall_out
);

   logic [WIDTH-1:0] prev_q;
   logic [2:0]       armed_q;

   // the synchroniser ahead leaves reset at zero for two edges, so a pin held high
   // through reset would look like a rising edge; stay blind until prev_q holds a real level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q  <= '0;
         armed_q <= 3'h0;
      end else begin
         prev_q  <= level_in;
         armed_q <= {armed_q[1:0], 1'b1};
      end
   end

   assign rise_out = armed_q[2] ? (level_in & ~prev_q) : '0;
   assign fall_out = armed_q[2] ? (~level_in & prev_q) : '0;

endmodule // iefc_edge_detect

// ### logic/iefc_top.sv
// interrupt enable and flag control with apb register access
//
// How it works
// - flags set on their source events regardless of any enable bit.
// - control bit 7 global enable passes enabled interrupts, zero blocks all.
// - control bit 6 gates every peripheral source onto the request.
// - control bit 5 enables the timer zero overflow source.
// - control bit 4 enables the external edge input source.
// - control bit 3 enables the pin-change source.
// - control bit 2 sets on timer zero overflow, holds until a control write clears it.
// - control bit 1 sets on a qualifying external edge.
// - control bit 0 reads one while any per-pin change flag is set.
// - pin-change summary is read-only, clears once all per-pin flags clear.
// - control register readable and writable except the summary bit.
// - all implemented control and enable bits reset to zero.
// - peripheral enable bit 6 enables conversion done.
// - peripheral enable bit 4 enables oscillator overflow.
// - peripheral enable bit 3 enables logic cell.
// - peripheral enable bit 1 enables timer match.
// - peripheral enable bits 7, 5, 2, 0 read zero and ignore writes.
// - edge input flag sets on rising edge if polarity one, else falling.
// - peripheral flags at bits 6, 4, 3, 1; software clears them.
// - request reaches the core within three to five instruction cycles.
//
// Design decisions made here: the register addresses and register access over APB.
module iefc_top
   import iefc_pkg::*;
#(
   parameter int PIN_COUNT = IEFC_PIN_COUNT
) (
   // clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output      logic [31:0]          prdata,
   output      logic                 pready,
   output      logic                 pslverr,
   // event pulses from on-chip sources, same clock
   input  wire logic                 timer_zero_overflow,
   input  wire logic                 conversion_done,
   input  wire logic                 osc_overflow,
   input  wire logic                 logic_cell_event,
   input  wire logic                 timer_match,
   // asynchronous pins
   input  wire logic                 edge_input_pin,
   input  wire logic [PIN_COUNT-1:0] change_pins,
   // request to the core
   output      logic                 core_irq
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0]           control_q;
   logic [7:0]           periph_en_q;
   logic [7:0]           periph_flg_q;
   logic [PIN_COUNT-1:0] per_pin_change_flags_q;
   logic                 edge_polarity_select_q;
   logic                 core_irq_q;
   logic [31:0]          prdata_q;

   // ----------------------------------------
   // pin synchronisation and edge detection
   // ----------------------------------------
   logic [PIN_COUNT:0] pins_sync;
   logic [PIN_COUNT:0] pins_rise;
   logic [PIN_COUNT:0] pins_fall;

   iefc_sync #(
      .WIDTH (PIN_COUNT + 1)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({change_pins, edge_input_pin}),
      .sync_out (pins_sync)
   );

   iefc_edge_detect #(
      .WIDTH (PIN_COUNT + 1)
   ) u_edge (
      .pclk     (pclk),
      .presetn  (presetn),
      .level_in (pins_sync),
      .rise_out (pins_rise),
      .fall_out (pins_fall)
   );

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire bus_write   = psel & penable & pwrite;
   wire lane0       = pstrb[0];
   wire hit_control = (paddr == IEFC_ADDR_CONTROL);
   wire hit_pen     = (paddr == IEFC_ADDR_PERIPH_EN);
   wire hit_pflg    = (paddr == IEFC_ADDR_PERIPH_FLG);
   wire hit_pins    = (paddr == IEFC_ADDR_PIN_FLAGS);
   wire hit_option  = (paddr == IEFC_ADDR_OPTION);
   wire hit_any     = hit_control | hit_pen | hit_pflg | hit_pins | hit_option;
   wire wr_lane     = bus_write & lane0;
   wire wr_control  = wr_lane & hit_control;
   wire wr_pen      = wr_lane & hit_pen;
   wire wr_pflg     = wr_lane & hit_pflg;
   wire wr_pins     = wr_lane & hit_pins;
   wire wr_option   = wr_lane & hit_option;
   wire [7:0] wbyte = pwdata[7:0];

   // zero-wait slave; unmapped addresses get an error
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   // ----------------------------------------
   // event sources
   // ----------------------------------------
   // flags are set by hardware with no look at any enable bit
   wire ev_timer = timer_zero_overflow;
   wire ev_edge  = edge_polarity_select_q ? pins_rise[0] : pins_fall[0];
   wire [PIN_COUNT-1:0] ev_pins = pins_rise[PIN_COUNT:1] | pins_fall[PIN_COUNT:1];
   wire [7:0] ev_periph = ({1'b0, conversion_done, 1'b0, osc_overflow,
                            logic_cell_event, 1'b0, timer_match, 1'b0}
                           & IEFC_PERIPH_MASK);

   // set-over-clear merge used by every software-clearable flag
   function automatic logic flag_next(input logic cur, input logic wr,
                                      input logic wval, input logic set);
      flag_next = set | (wr ? wval : cur);
   endfunction

   // ----------------------------------------
   // next values
   // ----------------------------------------
   logic [7:0] control_d;
   logic [7:0] periph_flg_d;
   logic [PIN_COUNT-1:0] pins_d;
   wire  pin_summary = |per_pin_change_flags_q;

   always_comb begin
      control_d = control_q;
      if (wr_control) begin
         control_d[7:3] = wbyte[7:3];
      end
      control_d[IEFC_TIMER_FLG_BIT] = flag_next(control_q[IEFC_TIMER_FLG_BIT],
                                                wr_control,
                                                wbyte[IEFC_TIMER_FLG_BIT],
                                                ev_timer);
      control_d[IEFC_EDGE_FLG_BIT]  = flag_next(control_q[IEFC_EDGE_FLG_BIT],
                                                wr_control,
                                                wbyte[IEFC_EDGE_FLG_BIT],
                                                ev_edge);
      // summary ignores writes and follows the per-pin flags
      control_d[IEFC_PIN_SUM_BIT] = 1'b0;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         periph_flg_d[i] = flag_next(periph_flg_q[i], wr_pflg, wbyte[i], ev_periph[i]);
      end
      periph_flg_d = periph_flg_d & IEFC_PERIPH_MASK;
   end

   always_comb begin
      for (int i = 0; i < PIN_COUNT; i++) begin
         pins_d[i] = flag_next(per_pin_change_flags_q[i], wr_pins, wbyte[i], ev_pins[i]);
      end
   end

   // ----------------------------------------
   // request combine
   // ----------------------------------------
   wire core_hit = (control_q[IEFC_TIMER_EN_BIT] & control_q[IEFC_TIMER_FLG_BIT])
                 | (control_q[IEFC_EDGE_EN_BIT]  & control_q[IEFC_EDGE_FLG_BIT])
                 | (control_q[IEFC_PIN_EN_BIT]   & pin_summary);
   wire [7:0] periph_act = periph_en_q & periph_flg_q;
   wire periph_hit = control_q[IEFC_PERIPH_GRP_BIT] & (|periph_act);
   wire irq_d      = control_q[IEFC_GLOBAL_BIT] & (core_hit | periph_hit);

   // registered request adds one cycle, well inside the core latency window
   assign core_irq = core_irq_q;

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   wire [7:0] control_view = {control_q[7:1], pin_summary};
   wire [7:0] rd_byte = hit_control ? control_view :
                        hit_pen     ? periph_en_q :
                        hit_pflg    ? periph_flg_q :
                        hit_pins    ? 8'(per_pin_change_flags_q) :
                        hit_option  ? 8'(edge_polarity_select_q) << IEFC_EDGE_POL_BIT :
                                      8'h00;
   wire rd_take = psel & ~penable & ~pwrite;

   assign prdata = prdata_q;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_q              <= IEFC_CONTROL_RST;
         periph_en_q            <= IEFC_PERIPH_RST;
         periph_flg_q           <= IEFC_PERIPH_RST;
         per_pin_change_flags_q <= '0;
         edge_polarity_select_q <= 1'b0;
         core_irq_q             <= 1'b0;
         prdata_q               <= 32'h0000_0000;
      end else begin
         control_q              <= control_d;
         periph_flg_q           <= periph_flg_d;
         per_pin_change_flags_q <= pins_d;
         core_irq_q             <= irq_d;
         if (wr_pen) begin
            periph_en_q <= wbyte & IEFC_PERIPH_MASK;
         end
         if (wr_option) begin
            edge_polarity_select_q <= wbyte[IEFC_EDGE_POL_BIT];
         end
         // read data captured in setup, stable through the access phase
         if (rd_take) begin
            prdata_q <= {24'h000000, rd_byte};
         end
      end
   end

endmodule // iefc_top

// ### dv/iefc_monitor.sv
// checker: apb answers and request gating of the interrupt control block
module iefc_monitor
   import iefc_pkg::*;
#(
   parameter int PIN_COUNT = IEFC_PIN_COUNT
) (
   // clock, reset and apb
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [3:0]           pstrb,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   // events, pins and request
   input wire logic                 timer_zero_overflow,
   input wire logic                 conversion_done,
   input wire logic                 osc_overflow,
   input wire logic                 logic_cell_event,
   input wire logic                 timer_match,
   input wire logic                 edge_input_pin,
   input wire logic [PIN_COUNT-1:0] change_pins,
   input wire logic                 core_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // enables move only on apb writes, so this shadow of them is exact
   logic [7:0] ctl_q;
   logic [7:0] pen_q;
   logic       wr_any;
   logic       mapped;
   assign wr_any = psel && penable && pwrite && pstrb[0];
   assign mapped = paddr inside {IEFC_ADDR_CONTROL, IEFC_ADDR_PERIPH_EN, IEFC_ADDR_PERIPH_FLG,
                                 IEFC_ADDR_PIN_FLAGS, IEFC_ADDR_OPTION};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= 8'h00;
         pen_q <= 8'h00;
      end else begin
         if (wr_any && paddr == IEFC_ADDR_CONTROL) ctl_q <= pwdata[7:0];
         if (wr_any && paddr == IEFC_ADDR_PERIPH_EN) pen_q <= pwdata[7:0] & IEFC_PERIPH_MASK;
      end
   end
   // no write may move the enables while the request builds up
   sequence s_quiet;
      !wr_any ##1 !wr_any;
   endsequence
   AST_PREADY: assert property (pready) else $error("pready low");
   AST_SLVERR: assert property (pslverr == (psel && penable && !mapped))
      else $error("pslverr differs from the address decode");
   AST_UPPER: assert property (prdata[31:8] == 24'h000000) else $error("upper read bits set");
   AST_GLOBAL_OFF: assert property (!ctl_q[7] |-> ##1 !core_irq)
      else $error("request with global enable off");
   AST_NO_SOURCE: assert property (!(ctl_q[6] && |pen_q) && ctl_q[5:3] == 3'h0 |-> ##1 !core_irq)
      else $error("request with no source enabled");
   AST_TIMER_IRQ: assert property (timer_zero_overflow && ctl_q[7] && ctl_q[5] ##0 s_quiet |-> ##1 core_irq)
      else $error("timer overflow did not raise the request");
   AST_CONV_IRQ: assert property (conversion_done && ctl_q[7] && ctl_q[6] && pen_q[6] ##0 s_quiet
      |-> ##1 core_irq) else $error("conversion done did not raise the request");
   AST_MATCH_IRQ: assert property (timer_match && ctl_q[7] && ctl_q[6] && pen_q[1] ##0 s_quiet
      |-> ##1 core_irq) else $error("timer match did not raise the request");
endmodule // iefc_monitor

bind iefc_top iefc_monitor #(.PIN_COUNT(PIN_COUNT)) iefc_monitor_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .timer_zero_overflow(timer_zero_overflow), .conversion_done(conversion_done),
   .osc_overflow(osc_overflow), .logic_cell_event(logic_cell_event), .timer_match(timer_match),
   .edge_input_pin(edge_input_pin), .change_pins(change_pins), .core_irq(core_irq));

// ### dv/iefc_src_model.sv
// partner model: on-chip event sources and external pins feeding the block
module iefc_src_model (
   // clock
   input wire logic       pclk,
   // events and pins
   output     logic [4:0] ev,
   output     logic       edge_pin,
   output     logic [3:0] pins
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      ev = 5'h00;
      edge_pin = 1'b0;
      pins = 4'h0;
   end
   // sources pulse one cycle; a held level would set the flag again each cycle
   task automatic pulse(input int k);
      @(posedge pclk);
      ev[k] <= 1'b1;
      @(posedge pclk);
      ev[k] <= 1'b0;
   endtask
   task automatic drive(input logic e, input logic [3:0] p);
      @(posedge pclk);
      edge_pin <= e;
      pins <= p;
      // two synchroniser edges pass, and the flag register takes the detector pulse on the third
      repeat (3) @(posedge pclk);
   endtask
endmodule // iefc_src_model

// ### dv/tb_interrupt_enable_flag_control.sv
// testbench: register access, flag setting and request gating of the interrupt control block
module tb_interrupt_enable_flag_control
   import iefc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] CTL = IEFC_ADDR_CONTROL;
   localparam logic [11:0] PEN = IEFC_ADDR_PERIPH_EN;
   localparam logic [11:0] FLG = IEFC_ADDR_PERIPH_FLG;
   localparam logic [11:0] PIN = IEFC_ADDR_PIN_FLAGS;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, core_irq, edge_pin, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0]  pstrb, pins;
   logic [4:0]  ev;
   int          err_count, check_count;
   // per source: flag address, flag bit, control with enable off and on
   logic [11:0] fa [5] = '{CTL, FLG, FLG, FLG, FLG};
   logic [7:0]  fm [5] = '{8'h04, 8'h40, 8'h10, 8'h08, 8'h02};
   logic [7:0]  c0 [5] = '{8'h84, 8'h80, 8'h80, 8'h80, 8'h80};
   logic [7:0]  c1 [5] = '{8'hA4, 8'hC0, 8'hC0, 8'hC0, 8'hC0};
   iefc_top iefc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_zero_overflow(ev[0]), .conversion_done(ev[1]),
      .osc_overflow(ev[2]), .logic_cell_event(ev[3]), .timer_match(ev[4]),
      .edge_input_pin(edge_pin), .change_pins(pins), .core_irq(core_irq));
   iefc_src_model iefc_src_model_i (.pclk(pclk), .ev(ev), .edge_pin(edge_pin), .pins(pins));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; the request stands until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         report_and_stop;
      end else begin
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] x);
      apb(1'b0, a, 8'h00);
      chk(r, {24'h000000, x});
   endtask
   task automatic irq(input logic x);
      repeat (6) @(posedge pclk);
      chk({31'h0, core_irq}, {31'h0, x});
   endtask
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h0, 12'h000, 32'h0, 4'hF};
      err_count = 0;
      check_count = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(CTL, 8'h00);
      rd(PEN, 8'h00);
      apb(1'b1, PEN, 8'hFF);
      rd(PEN, 8'h5A);
      apb(1'b1, CTL, 8'hFF);
      rd(CTL, 8'hFE);
      irq(1'b1);
      apb(1'b1, CTL, 8'h7E);
      irq(1'b0);
      apb(1'b1, CTL, 8'h00);
      rd(CTL, 8'h00);
      for (int i = 0; i < 5; i++) begin
         iefc_src_model_i.pulse(i);
         irq(1'b0);
         rd(fa[i], fm[i]);
         apb(1'b1, PEN, fm[i]);
         apb(1'b1, CTL, c0[i]);
         irq(1'b0);
         apb(1'b1, CTL, c1[i]);
         irq(1'b1);
         apb(1'b1, fa[i], c1[i] & ~fm[i] & 8'hA0);
         irq(1'b0);
         iefc_src_model_i.pulse(i);
         irq(1'b1);
         apb(1'b1, fa[i], c1[i] & ~fm[i] & 8'hA0);
      end
      apb(1'b1, CTL, 8'h00);
      apb(1'b1, IEFC_ADDR_OPTION, 8'h40);
      iefc_src_model_i.drive(1'b1, 4'h0);
      rd(CTL, 8'h02);
      apb(1'b1, CTL, 8'h00);
      iefc_src_model_i.drive(1'b0, 4'h0);
      rd(CTL, 8'h00);
      apb(1'b1, IEFC_ADDR_OPTION, 8'h00);
      iefc_src_model_i.drive(1'b1, 4'h0);
      rd(CTL, 8'h00);
      iefc_src_model_i.drive(1'b0, 4'h0);
      rd(CTL, 8'h02);
      apb(1'b1, CTL, 8'h92);
      irq(1'b1);
      apb(1'b1, CTL, 8'h00);
      iefc_src_model_i.drive(1'b0, 4'h4);
      irq(1'b0);
      rd(CTL, 8'h01);
      rd(PIN, 8'h04);
      apb(1'b1, CTL, 8'h88);
      rd(CTL, 8'h89);
      irq(1'b1);
      apb(1'b1, PIN, 8'h00);
      rd(CTL, 8'h88);
      fork
         apb(1'b1, CTL, 8'h00);
         begin
            @(posedge pclk);
            iefc_src_model_i.pulse(0);
         end
      join
      rd(CTL, 8'h04);
      apb(1'b0, 12'h020, 8'h00);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h1);
      pstrb <= 4'hE;
      apb(1'b1, PEN, 8'hFF);
      pstrb <= 4'hF;
      rd(PEN, 8'h02);
      apb(1'b1, PEN, 8'hFF);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(PEN, 8'h00);
      rd(CTL, 8'h00);
      report_and_stop;
   end
endmodule // tb_interrupt_enable_flag_control
